// >>> rtl/bpm_monitor_regs.sv
// Monitor registers, event flags and interrupt gating of the backup manager.
// Assumes a simple synchronous register port driven by the serial slave.
`timescale 1ns/1ns
`include "bpm_defines.svh"

// Behaviour
// (R01) Current sample is 6-bit code in bits 7..2, 0.15 A per step.
// (R02) Bit 0 of current register shows ESR step above selected threshold.
// (R03) Rail and source voltage samples are 8-bit codes, 64 mV per step.
// (R04) Storage voltage sample is 8-bit code, 0.15 V per step.
// (R05) Over-voltage limit field bits 4..0, resets 0x1D, bits 7..5 read zero.
// (R06) Mask bit 0 lets event interrupt; 1 still sets flag, no interrupt.
// (R07) Mask bits 7..4: input OV, input OC, storage short, reverse block.
// (R08) Mask bits 3..0: cap done, ADC done, hot warning, thermal shutdown.
// (R09) Capacitance measurement starts only on rising measurement enable.
// (R10) ADC conversion starts only on rising ADC enable.
// (R11) Input over-voltage event counts only while its enable is set.
// (R12) Reverse-block event counts only while its protection is enabled.
// (R13) All ADC result registers reset to zero.
// (R14) Mask register resets to zero.
// (R15) Flags stay set until host writes 1 after event has gone.
// (R16) ESR threshold codes 00..11 select 50, 100, 150, 200 mV.
// (R17) Flag bits use the same order as mask bits.
// (R18) Interrupt active while any unmasked flag is set.
// (R19) Result registers update only when a conversion completes.
module bpm_monitor_regs
	import bpm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       adc_done,
	input  wire logic [5:0] adc_current,
	input  wire logic [7:0] adc_rail_v,
	input  wire logic [7:0] adc_source_v,
	input  wire logic [7:0] adc_storage_v,
	input  wire logic [9:0] esr_step_mv,
	input  wire logic       esr_valid,
	input  wire logic       cap_done,
	input  wire logic       cond_in_ov,
	input  wire logic       cond_in_oc,
	input  wire logic       cond_str_sc,
	input  wire logic       cond_rev_blk,
	input  wire logic       cond_hot_warn,
	input  wire logic       cond_therm_sd,
	input  wire logic       source_limit_protect_en,
	input  wire logic       reverse_block_protection,
	input  wire logic [1:0] esr_threshold_sel,
	input  wire logic       cap_measure_en,
	input  wire logic       adc_enable,
	output logic            cap_measure_start,
	output logic            adc_start,
	output logic      [4:0] storage_overvoltage_threshold,
	output logic            int_n
);
	// ==========================================================
	// Storage
	bpm_byte_t  source_current_sample_esr_status;
	bpm_byte_t  load_rail_voltage_sample;
	bpm_byte_t  source_voltage_sample;
	bpm_byte_t  storage_voltage_sample;
	bpm_byte_t  interrupt_suppress_ctrl;
	bpm_byte_t  event_flags;
	logic [4:0] ov_limit;
	logic [9:0] esr_limit_mv;
	logic       capacitor_resistance_error;
	bpm_byte_t  event_raw;
	bpm_byte_t  next_flags;
	bpm_byte_t  clear_req;
	bpm_byte_t  next_suppress;
	logic [5:0] current_code;

	// ==========================================================
	// Start pulses
	bpm_rise_detect u_cap_rise (
		.clk   (clk),
		.rst   (rst),
		.level (cap_measure_en),
		.rise  (cap_measure_start)              // R09
	);

	bpm_rise_detect u_adc_rise (
		.clk   (clk),
		.rst   (rst),
		.level (adc_enable),
		.rise  (adc_start)                      // R10
	);

	// ==========================================================
	// ESR comparison
	always_comb begin
		unique case (bpm_esr_sel_e'(esr_threshold_sel))   // R16
			BPM_ESR_50:  esr_limit_mv = `BPM_ESR_MV_00;
			BPM_ESR_100: esr_limit_mv = `BPM_ESR_MV_01;
			BPM_ESR_150: esr_limit_mv = `BPM_ESR_MV_10;
			BPM_ESR_200: esr_limit_mv = `BPM_ESR_MV_11;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			capacitor_resistance_error <= 1'b0;
		end else if (esr_valid) begin
			capacitor_resistance_error <= esr_step_mv > esr_limit_mv; // R02
		end
	end

	// ==========================================================
	// ADC results, held until the next completed conversion
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_rail_voltage_sample <= `BPM_RST_SAMPLE;       // R13
			source_voltage_sample    <= `BPM_RST_SAMPLE;       // R13
			storage_voltage_sample   <= `BPM_RST_SAMPLE;       // R13
			current_code             <= 6'h00;                 // R13
		end else if (adc_done) begin                         // R19
			current_code             <= adc_current;           // R01
			load_rail_voltage_sample <= adc_rail_v;            // R03
			source_voltage_sample    <= adc_source_v;          // R03
			storage_voltage_sample   <= adc_storage_v;         // R04
		end
	end

	// Bit 1 is reserved and reads zero
	assign source_current_sample_esr_status = {current_code, 1'b0,
		capacitor_resistance_error};                         // R01 R02

	// ==========================================================
	// Writable registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ov_limit <= `BPM_RST_OV_LIMIT;                     // R05
		end else if (reg_wr && reg_addr == `BPM_OFS_OV_LIMIT) begin
			ov_limit <= reg_wdata[`BPM_OV_WIDTH-1:0];          // R05
		end
	end

	assign storage_overvoltage_threshold = ov_limit;

	always_comb begin
		next_suppress = interrupt_suppress_ctrl;
		if (reg_wr && reg_addr == `BPM_OFS_SUPPRESS) begin
			next_suppress = reg_wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interrupt_suppress_ctrl <= `BPM_RST_SUPPRESS;      // R14
		end else begin
			interrupt_suppress_ctrl <= next_suppress;
		end
	end

	// ==========================================================
	// Event flags: set wins over a clear in the same cycle
	always_comb begin
		event_raw = 8'h00;
		event_raw[`BPM_EV_IN_OV]    = cond_in_ov &
			source_limit_protect_en;                         // R11
		event_raw[`BPM_EV_IN_OC]    = cond_in_oc;            // R07
		event_raw[`BPM_EV_STR_SC]   = cond_str_sc;           // R07
		event_raw[`BPM_EV_REV_BLK]  = cond_rev_blk &
			reverse_block_protection;                        // R12
		event_raw[`BPM_EV_CAP_DONE] = cap_done;              // R08
		event_raw[`BPM_EV_ADC_DONE] = adc_done;              // R08
		event_raw[`BPM_EV_HOT_WARN] = cond_hot_warn;         // R08
		event_raw[`BPM_EV_THERM_SD] = cond_therm_sd;         // R08
	end

	always_comb begin
		clear_req = 8'h00;
		if (reg_wr && reg_addr == `BPM_OFS_FLAGS) begin
			clear_req = reg_wdata;
		end
	end

	generate
		for (genvar i = 0; i < 8; i++) begin : g_flag
			always_comb begin
				next_flags[i] = event_raw[i] |
					(event_flags[i] & ~clear_req[i]);        // R15
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			event_flags <= `BPM_RST_FLAGS;
		end else begin
			event_flags <= next_flags;                       // R17
		end
	end

	// ==========================================================
	// Interrupt pin, active low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_n <= 1'b1;
		end else begin
			int_n <= ~|(next_flags & ~next_suppress);       // R06 R18
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`BPM_OFS_CURRENT_ESR:
					reg_rdata <= source_current_sample_esr_status;
				`BPM_OFS_RAIL_V:    reg_rdata <= load_rail_voltage_sample;
				`BPM_OFS_OV_LIMIT:  reg_rdata <= {3'b000, ov_limit}; // R05
				`BPM_OFS_SOURCE_V:  reg_rdata <= source_voltage_sample;
				`BPM_OFS_STORAGE_V: reg_rdata <= storage_voltage_sample;
				`BPM_OFS_SUPPRESS:  reg_rdata <= interrupt_suppress_ctrl;
				`BPM_OFS_FLAGS:     reg_rdata <= event_flags;
				default:            reg_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Checks
	flag_sticky_a: assert property (@(posedge clk) disable iff (rst) // R15
		event_flags[5] && !(clear_req[5]) |=> event_flags[5])
		else $error("flag dropped without a clear");

	in_ov_gate_a: assert property (@(posedge clk) disable iff (rst) // R11
		!source_limit_protect_en && !event_flags[7] && cond_in_ov
		|=> !event_flags[7])
		else $error("input over-voltage flagged while disabled");

	rev_gate_a: assert property (@(posedge clk) disable iff (rst) // R12
		!reverse_block_protection && !event_flags[4] && cond_rev_blk
		|=> !event_flags[4])
		else $error("reverse block flagged while disabled");

	mask_blocks_a: assert property (@(posedge clk) disable iff (rst) // R06
		(event_flags & ~interrupt_suppress_ctrl) == 8'h00 |-> int_n)
		else $error("interrupt with all flags masked");

	int_asserts_a: assert property (@(posedge clk) disable iff (rst) // R18
		(event_flags & ~interrupt_suppress_ctrl) != 8'h00 |-> !int_n)
		else $error("unmasked flag did not raise interrupt");

	adc_hold_a: assert property (@(posedge clk) disable iff (rst) // R19
		!adc_done |=> $stable(storage_voltage_sample))
		else $error("sample changed without a conversion");

	adc_load_a: assert property (@(posedge clk) disable iff (rst) // R03
		adc_done |=> load_rail_voltage_sample == $past(adc_rail_v))
		else $error("rail sample not loaded");

	ov_reserved_a: assert property (@(posedge clk) disable iff (rst) // R05
		reg_rd && reg_addr == `BPM_OFS_OV_LIMIT |=> reg_rdata[7:5] == 3'b000)
		else $error("reserved limit bits read nonzero");

	adc_flag_a: assert property (@(posedge clk) disable iff (rst) // R08
		adc_done |=> event_flags[2])
		else $error("adc done flag not set");

	cap_start_a: assert property (@(posedge clk) disable iff (rst) // R09
		cap_measure_start |-> cap_measure_en && !$past(cap_measure_en))
		else $error("measurement start without rising enable");

	adc_start_a: assert property (@(posedge clk) disable iff (rst) // R10
		adc_start |-> adc_enable && !$past(adc_enable))
		else $error("conversion start without rising enable");

	cur_load_a: assert property (@(posedge clk) disable iff (rst) // R01
		adc_done |=> source_current_sample_esr_status[7:`BPM_CUR_LSB] ==
			$past(adc_current))
		else $error("current sample not loaded");

	esr_limit_a: assert property (@(posedge clk) disable iff (rst) // R16
		esr_valid |=> source_current_sample_esr_status[`BPM_ESR_BIT] ==
			($past(esr_step_mv) >
			10'd50 * ({8'h00, $past(esr_threshold_sel)} + 10'd1)))
		else $error("ESR status does not follow the threshold");

	src_load_a: assert property (@(posedge clk) disable iff (rst) // R03
		adc_done |=> source_voltage_sample == $past(adc_source_v))
		else $error("source sample not loaded");

	stor_load_a: assert property (@(posedge clk) disable iff (rst) // R04
		adc_done |=> storage_voltage_sample == $past(adc_storage_v))
		else $error("storage sample not loaded");

	ov_write_a: assert property (@(posedge clk) disable iff (rst) // R05
		reg_wr && reg_addr == `BPM_OFS_OV_LIMIT |=>
			storage_overvoltage_threshold == $past(reg_wdata[4:0]))
		else $error("limit field not written");

	mask_write_a: assert property (@(posedge clk) disable iff (rst) // R06
		reg_wr && reg_addr == `BPM_OFS_SUPPRESS |=>
			interrupt_suppress_ctrl == $past(reg_wdata))
		else $error("mask register not written");

	flag_clear_a: assert property (@(posedge clk) disable iff (rst) // R15
		(event_flags & clear_req & ~event_raw) != 8'h00 |=>
			(event_flags & $past(event_flags & clear_req &
			~event_raw)) == 8'h00)
		else $error("written flag did not clear");

	flag_set_a: assert property (@(posedge clk) disable iff (rst) // R17
		event_raw != 8'h00 |=>
			(event_flags & $past(event_raw)) == $past(event_raw))
		else $error("event did not set its flag");
endmodule

// >>> rtl/bpm_defines.svh
// Register offsets, field positions and reset values of the monitor slice.
// Assumes an 8-bit register address and 8-bit data on the internal port.
`ifndef BPM_DEFINES_SVH
`define BPM_DEFINES_SVH

`define BPM_OFS_CURRENT_ESR   8'h09
`define BPM_OFS_RAIL_V        8'h0A
`define BPM_OFS_OV_LIMIT      8'h0B
`define BPM_OFS_SOURCE_V      8'h0C
`define BPM_OFS_STORAGE_V     8'h0D
`define BPM_OFS_SUPPRESS      8'h0E
`define BPM_OFS_FLAGS         8'h0F

`define BPM_RST_SAMPLE        8'h00
`define BPM_RST_OV_LIMIT      5'h1D
`define BPM_RST_SUPPRESS      8'h00
`define BPM_RST_FLAGS         8'h00

`define BPM_CUR_LSB           2
`define BPM_ESR_BIT           0
`define BPM_OV_WIDTH          5
`define BPM_OV_OFFSET_V       7

// ESR step thresholds in mV per two-bit code
`define BPM_ESR_MV_00         10'd50
`define BPM_ESR_MV_01         10'd100
`define BPM_ESR_MV_10         10'd150
`define BPM_ESR_MV_11         10'd200

`define BPM_EV_IN_OV          7
`define BPM_EV_IN_OC          6
`define BPM_EV_STR_SC         5
`define BPM_EV_REV_BLK        4
`define BPM_EV_CAP_DONE       3
`define BPM_EV_ADC_DONE       2
`define BPM_EV_HOT_WARN       1
`define BPM_EV_THERM_SD       0

`endif

// >>> rtl/bpm_pkg.sv
// Types shared by the monitor slice.
// Assumes nothing of its surroundings.
package bpm_pkg;
	typedef logic [7:0] bpm_byte_t;
	typedef enum logic [1:0] {
		BPM_ESR_50  = 2'b00,
		BPM_ESR_100 = 2'b01,
		BPM_ESR_150 = 2'b10,
		BPM_ESR_200 = 2'b11
	} bpm_esr_sel_e;
endpackage

// >>> rtl/bpm_rise_detect.sv
// Rising-edge detector for control bits that start an operation.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ns
module bpm_rise_detect
	import bpm_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic level,
	output logic      rise
);
	logic prev;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev <= 1'b0;
		end else begin
			prev <= level;
		end
	end

	assign rise = level & ~prev;

	rise_pulse_a: assert property (@(posedge clk) disable iff (rst)
		rise |=> !rise)
		else $error("rise pulse lasted more than one cycle");
endmodule

// >>> dv/bpm_host_model.sv
// Register host model that drives the byte-wide register port.
// Assumes reg_rdata is registered one cycle after the read strobe.
`timescale 1ns/1ns
module bpm_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr  = 8'h00,
	output logic            reg_wr    = 1'b0,
	output logic            reg_rd    = 1'b0,
	output logic      [7:0] reg_wdata = 8'h00,
	input  wire logic [7:0] reg_rdata
);
	// ==========================================================
	// Bus cycles; released lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench for the monitor register slice.
// Assumes the host model owns the register port; 125 MHz clock.
`timescale 1ns/1ns
module tb;
	logic       clk, rst, adc_done, esr_valid, cap_done, int_n;
	logic       cond_in_ov, cond_in_oc, cond_str_sc, cond_rev_blk;
	logic       cond_hot_warn, cond_therm_sd, cap_measure_en, adc_enable;
	logic       source_limit_protect_en, reverse_block_protection;
	logic       reg_wr, reg_rd, cap_measure_start, adc_start;
	logic [1:0] esr_threshold_sel;
	logic [4:0] storage_overvoltage_threshold;
	logic [5:0] adc_current;
	logic [7:0] adc_rail_v, adc_source_v, adc_storage_v, d, m;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, s0, s1, s2, s3;
	logic [9:0] esr_step_mv;
	int         n_fail, checked, seed, cyc;

	bpm_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	bpm_monitor_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .adc_done(adc_done),
		.adc_current(adc_current), .adc_rail_v(adc_rail_v),
		.adc_source_v(adc_source_v), .adc_storage_v(adc_storage_v),
		.esr_step_mv(esr_step_mv), .esr_valid(esr_valid),
		.cap_done(cap_done), .cond_in_ov(cond_in_ov),
		.cond_in_oc(cond_in_oc), .cond_str_sc(cond_str_sc),
		.cond_rev_blk(cond_rev_blk), .cond_hot_warn(cond_hot_warn),
		.cond_therm_sd(cond_therm_sd),
		.source_limit_protect_en(source_limit_protect_en),
		.reverse_block_protection(reverse_block_protection),
		.esr_threshold_sel(esr_threshold_sel),
		.cap_measure_en(cap_measure_en), .adc_enable(adc_enable),
		.cap_measure_start(cap_measure_start), .adc_start(adc_start),
		.storage_overvoltage_threshold(storage_overvoltage_threshold),
		.int_n(int_n));

	function automatic logic [9:0] thr_mv(input logic [1:0] sel);
		return 10'h032 * ({8'h00, sel} + 10'h001);
	endfunction
	function automatic logic [7:0] exp_reg(input logic [7:0] a, input logic w);
		case (a)
		8'h0B: return w ? 8'h1F : 8'h1D;
		8'h0E: return w ? 8'hFF : 8'h00;
		default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ev(input int i, input logic v);
		case (i)
		7: cond_in_ov = v;
		6: cond_in_oc = v;
		5: cond_str_sc = v;
		4: cond_rev_blk = v;
		3: cap_done = v;
		2: adc_done = v;
		1: cond_hot_warn = v;
		default: cond_therm_sd = v;
		endcase
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_sim();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		seed = 11;
		rst = 1'b1;
		{adc_done, esr_valid, cap_done, cond_in_ov, cond_in_oc} = '0;
		{cond_str_sc, cond_rev_blk, cond_hot_warn, cond_therm_sd} = '0;
		{cap_measure_en, adc_enable, source_limit_protect_en} = '0;
		reverse_block_protection = 1'b0;
		{adc_current, adc_rail_v, adc_source_v, adc_storage_v} = '0;
		{esr_step_mv, esr_threshold_sel} = '0;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("int_n", 8'h01, {7'h00, int_n});
		for (int p = 0; p < 2; p++) begin
			for (int a = 8; a <= 16; a++) begin
				host.rd(a[7:0], d);
				chk("reg", exp_reg(a[7:0], p[0]), d);
			end
			d = {3'h0, storage_overvoltage_threshold};
			chk("ovthr", exp_reg(8'h0B, p[0]), d);
			for (int a = 8; a <= 16; a++)
				host.wr(a[7:0], 8'hFF);
		end
		host.wr(8'h0E, 8'h00);
		for (int i = 0; i < 12; i++) begin
			{s0, s1, s2, s3} = $random(seed);
			step();
			{adc_current, adc_rail_v, adc_source_v, adc_storage_v} =
				{s0[5:0], s1, s2, s3};
			esr_threshold_sel = i[1:0];
			esr_step_mv = thr_mv(i[1:0]) + {8'h00, i[3:2]} - 10'h001;
			{adc_done, esr_valid} = 2'b11;
			step();
			{adc_done, esr_valid} = 2'b00;
			{adc_current, adc_rail_v, adc_source_v, adc_storage_v} =
				~{s0[5:0], s1, s2, s3};
			host.rd(8'h09, d);
			m = {s0[5:0], 1'b0, esr_step_mv > thr_mv(i[1:0])};
			chk("cur", m, d);
			host.rd(8'h0A, d);
			chk("rail", s1, d);
			host.rd(8'h0C, d);
			chk("src", s2, d);
			host.rd(8'h0D, d);
			chk("stor", s3, d);
		end
		host.wr(8'h0F, 8'hFF);
		step();
		{cap_measure_en, adc_enable} = 2'b11;
		#1;
		chk("start", 8'h03, {6'h00, cap_measure_start, adc_start});
		step();
		chk("start", 8'h00, {6'h00, cap_measure_start, adc_start});
		{cap_measure_en, adc_enable, cond_in_ov, cond_rev_blk} = 4'h3;
		step();
		{cond_in_ov, cond_rev_blk} = 2'b00;
		host.rd(8'h0F, d);
		chk("gated", 8'h00, d);
		chk("int_n", 8'h01, {7'h00, int_n});
		{source_limit_protect_en, reverse_block_protection} = 2'b11;
		for (int i = 0; i < 8; i++) begin
			m = $random(seed);
			host.wr(8'h0E, m);
			step();
			ev(i, 1'b1);
			step();
			chk("int_n", {7'h00, m[i]}, {7'h00, int_n});
			ev(i, 1'b0);
			host.rd(8'h0F, d);
			chk("flag", 8'h01 << i, d);
			host.wr(8'h0F, 8'h01 << i);
			host.rd(8'h0F, d);
			chk("clr", 8'h00, d);
			chk("int_n", 8'h01, {7'h00, int_n});
		end
		cond_therm_sd = 1'b1;
		host.wr(8'h0F, 8'h01);
		host.rd(8'h0F, d);
		chk("held", 8'h01, d);
		end_sim();
	end
endmodule
